// File: rtl/rtm_entry_check.sv
// combinational bcd range check of words written to time, calendar and alarm registers
`timescale 1ns/10ps
module rtm_entry_check (
  // written data and hour format
  input  wire logic [31:0] wdata,
  input  wire logic        hour_12,
  // one when the word would be invalid in that register
  output logic             bad_time,
  output logic             bad_cal,
  output logic             bad_talr,
  output logic             bad_calr
);

  function automatic logic bcd_in(input logic [7:0] v,
                                  input logic [7:0] lo,
                                  input logic [7:0] hi);
    bcd_in = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
  endfunction

  logic hour_ok;
  logic time_ok;
  logic date_ok;

  // hour range depends on 12/24 hour format; pm flag illegal in 24 h mode
  assign hour_ok = hour_12 ?
                   bcd_in({2'b00, wdata[21:16]}, 8'h01, 8'h12) :
                   (bcd_in({2'b00, wdata[21:16]}, 8'h00, 8'h23) && !wdata[22]);
  assign time_ok = bcd_in({1'b0, wdata[6:0]}, 8'h00, 8'h59) &&
                   bcd_in({1'b0, wdata[14:8]}, 8'h00, 8'h59) && hour_ok;
  assign date_ok = bcd_in({3'b000, wdata[20:16]}, 8'h01, 8'h12) &&
                   bcd_in({2'b00, wdata[29:24]}, 8'h01, 8'h31);

  assign bad_time = !time_ok;
  assign bad_talr = !time_ok;
  assign bad_cal  = !(bcd_in({1'b0, wdata[6:0]}, 8'h19, 8'h20) &&
                      bcd_in(wdata[15:8], 8'h00, 8'h99) &&
                      bcd_in({5'b00000, wdata[23:21]}, 8'h01, 8'h07) &&
                      date_ok);
  assign bad_calr = !date_ok;

endmodule

// File: rtl/rtm_pkg.sv
// shared constants for the rtc mask, validity and write-protect block
package rtm_pkg;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [31:0] ADDR_MODE    = 32'h400E_1264;
  localparam logic [31:0] ADDR_TIME    = 32'h400E_1268;
  localparam logic [31:0] ADDR_CAL     = 32'h400E_126C;
  localparam logic [31:0] ADDR_TALR    = 32'h400E_1270;
  localparam logic [31:0] ADDR_CALR    = 32'h400E_1274;
  localparam logic [31:0] ADDR_STATUS  = 32'h400E_1278;
  localparam logic [31:0] ADDR_SCLR    = 32'h400E_127C;
  localparam logic [31:0] ADDR_IEN     = 32'h400E_1280;
  localparam logic [31:0] ADDR_IDIS    = 32'h400E_1284;
  localparam logic [31:0] ADDR_IMASK   = 32'h400E_1288;
  localparam logic [31:0] ADDR_VALID   = 32'h400E_128C;
  localparam logic [31:0] ADDR_WPMODE  = 32'h400E_1344;

  // ****************************************************************
  // field positions and widths
  // ****************************************************************
  localparam int NUM_SRC      = 5;
  localparam int SRC_ACK      = 0;
  localparam int SRC_ALARM    = 1;
  localparam int SRC_SECOND   = 2;
  localparam int SRC_TIME     = 3;
  localparam int SRC_CAL      = 4;
  localparam int NV_TIME      = 0;
  localparam int NV_CAL       = 1;
  localparam int NV_TALR      = 2;
  localparam int NV_CALR      = 3;
  localparam int WP_ON_BIT    = 0;
  localparam int KEY_LSB      = 8;
  localparam int MODE_H12_BIT = 0;
  localparam int MODE_W       = 8;

  // ****************************************************************
  // key and values after reset
  // ****************************************************************
  localparam logic [23:0] PROTECT_KEY = 24'h52_5443;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [4:0]  RST_SRC     = 5'h00;
  localparam logic [3:0]  RST_NV      = 4'h0;
  localparam logic        RST_WP      = 1'b0;
  localparam logic [7:0]  RST_MODE    = 8'h00;

endpackage

// File: rtl/rtm_regs.sv
// rtc interrupt mask, entry validity and write-protect registers on apb
//
// Notes on behaviour
// RULE1 - a one written to the calendar-event enable bit enables that interrupt
// RULE2 - disable register bits 0..4 clear the matching mask bit on one
// RULE3 - second and time-event disable bits turn those interrupts off
// RULE4 - mask register bits 0..4 read back the five enable states
// RULE5 - bit 0 of valid flags: time register written with invalid data
// RULE6 - bit 1 of valid flags: calendar register written with invalid data
// RULE7 - bit 2 of valid flags: time alarm written with invalid data
// RULE8 - bit 3 of valid flags: calendar alarm written with invalid data
// RULE9 - correct key with bit 0 clear turns write protection off
// RULE10 - correct key with bit 0 set turns write protection on
// RULE11 - protection on blocks writes to mode and both alarm registers
// RULE12 - alarm match sets a sticky alarm flag feeding the alarm interrupt
// RULE13 - ones written to the status clear register clear status flags
// RULE14 - interrupt output is high while any enabled status flag is set
// RULE15 - a wrong key leaves the protection state untouched
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
module rtm_regs (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // one-cycle events from the counters and comparator
  input  wire logic        ev_update_ack,
  input  wire logic        ev_alarm_match,
  input  wire logic        ev_second,
  input  wire logic        ev_time,
  input  wire logic        ev_calendar,
  // configuration towards counters and alarm comparator
  output logic [7:0]       mode_cfg,
  output logic [31:0]      time_value,
  output logic [31:0]      cal_value,
  output logic [31:0]      time_alarm,
  output logic [31:0]      cal_alarm,
  output logic             write_protect_on,
  // interrupt
  output logic             irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [rtm_pkg::NUM_SRC-1:0] status;
  logic [rtm_pkg::NUM_SRC-1:0] irq_mask;
  logic [3:0]                  nv_flags;
  logic [rtm_pkg::NUM_SRC-1:0] src_event;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // one wait state: pready rises in the second access cycle so that
  // read data and the error answer can both come from flip-flops
  logic        acc_wait;
  logic        acc_done;
  logic        wr_done;
  logic        hit_mode;
  logic        hit_time;
  logic        hit_cal;
  logic        hit_talr;
  logic        hit_calr;
  logic        hit_status;
  logic        hit_sclr;
  logic        hit_ien;
  logic        hit_idis;
  logic        hit_imask;
  logic        hit_valid;
  logic        hit_wp;
  logic        hit_any;
  logic        key_ok;
  logic        wr_mode;
  logic        wr_time;
  logic        wr_cal;
  logic        wr_talr;
  logic        wr_calr;
  logic        wr_sclr;
  logic        wr_ien;
  logic        wr_idis;
  logic        wr_wp;
  logic [31:0] next_prdata;
  logic        bad_time;
  logic        bad_cal;
  logic        bad_talr;
  logic        bad_calr;
  logic        rd_load;
  logic        next_pready;
  logic        next_pslverr;

  assign acc_wait   = psel && penable && !pready;
  assign acc_done   = psel && penable && pready;
  assign wr_done    = acc_done && pwrite;

  assign hit_mode   = (paddr == rtm_pkg::ADDR_MODE);
  assign hit_time   = (paddr == rtm_pkg::ADDR_TIME);
  assign hit_cal    = (paddr == rtm_pkg::ADDR_CAL);
  assign hit_talr   = (paddr == rtm_pkg::ADDR_TALR);
  assign hit_calr   = (paddr == rtm_pkg::ADDR_CALR);
  assign hit_status = (paddr == rtm_pkg::ADDR_STATUS);
  assign hit_sclr   = (paddr == rtm_pkg::ADDR_SCLR);
  assign hit_ien    = (paddr == rtm_pkg::ADDR_IEN);
  assign hit_idis   = (paddr == rtm_pkg::ADDR_IDIS);
  assign hit_imask  = (paddr == rtm_pkg::ADDR_IMASK);
  assign hit_valid  = (paddr == rtm_pkg::ADDR_VALID);
  assign hit_wp     = (paddr == rtm_pkg::ADDR_WPMODE);
  assign hit_any    = hit_mode || hit_time || hit_cal || hit_talr ||
                      hit_calr || hit_status || hit_sclr || hit_ien ||
                      hit_idis || hit_imask || hit_valid || hit_wp;

  // protected registers silently drop the write; the bus still completes
  assign wr_mode    = wr_done && hit_mode && !write_protect_on; // RULE11
  assign wr_talr    = wr_done && hit_talr && !write_protect_on; // RULE11
  assign wr_calr    = wr_done && hit_calr && !write_protect_on; // RULE11
  assign wr_time    = wr_done && hit_time;
  assign wr_cal     = wr_done && hit_cal;
  assign wr_sclr    = wr_done && hit_sclr;
  assign wr_ien     = wr_done && hit_ien;
  assign wr_idis    = wr_done && hit_idis;
  assign key_ok     = (pwdata[31:rtm_pkg::KEY_LSB] == rtm_pkg::PROTECT_KEY);
  assign wr_wp      = wr_done && hit_wp && key_ok; // RULE15

  // the answer comes one cycle into the access phase, never later
  assign next_pready  = acc_wait;
  assign next_pslverr = acc_wait && !hit_any;
  assign rd_load      = acc_wait && !pwrite;

  // ****************************************************************
  // read data
  // ****************************************************************
  // write-only registers and the key field read as zero
  logic [31:0] word_mode;
  logic [31:0] word_status;
  logic [31:0] word_imask;
  logic [31:0] word_valid;
  logic [31:0] word_wp;

  assign word_mode   = {24'h00_0000, mode_cfg};
  assign word_status = {27'h000_0000, status};
  assign word_imask  = {27'h000_0000, irq_mask}; // RULE4
  assign word_valid  = {28'h000_0000, nv_flags};
  assign word_wp     = {31'h0000_0000, write_protect_on};

  always_comb begin
    next_prdata = rtm_pkg::RST_WORD;
    if (hit_mode) begin
      next_prdata = word_mode;
    end else if (hit_time) begin
      next_prdata = time_value;
    end else if (hit_cal) begin
      next_prdata = cal_value;
    end else if (hit_talr) begin
      next_prdata = time_alarm;
    end else if (hit_calr) begin
      next_prdata = cal_alarm;
    end else if (hit_status) begin
      next_prdata = word_status;
    end else if (hit_imask) begin
      next_prdata = word_imask; // RULE4
    end else if (hit_valid) begin
      next_prdata = word_valid;
    end else if (hit_wp) begin
      next_prdata = word_wp;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= rtm_pkg::RST_WORD;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      if (rd_load) begin
        prdata <= next_prdata;
      end
    end
  end

  // ****************************************************************
  // entry validity check
  // ****************************************************************
  rtm_entry_check u_check (
    .wdata    (pwdata),
    .hour_12  (mode_cfg[rtm_pkg::MODE_H12_BIT]),
    .bad_time (bad_time),
    .bad_cal  (bad_cal),
    .bad_talr (bad_talr),
    .bad_calr (bad_calr)
  );

  // each flag follows the most recent accepted write to its register;
  // a refused write to a locked alarm leaves its flag alone as well
  logic [3:0] nv_wr;
  logic [3:0] nv_bad;

  assign nv_wr[rtm_pkg::NV_TIME]  = wr_time;
  assign nv_wr[rtm_pkg::NV_CAL]   = wr_cal;
  assign nv_wr[rtm_pkg::NV_TALR]  = wr_talr;
  assign nv_wr[rtm_pkg::NV_CALR]  = wr_calr;
  assign nv_bad[rtm_pkg::NV_TIME] = bad_time; // RULE5
  assign nv_bad[rtm_pkg::NV_CAL]  = bad_cal;  // RULE6
  assign nv_bad[rtm_pkg::NV_TALR] = bad_talr; // RULE7
  assign nv_bad[rtm_pkg::NV_CALR] = bad_calr; // RULE8

  genvar j;
  generate
    for (j = 0; j < $bits(nv_flags); j++) begin : g_nv
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          nv_flags[j] <= rtm_pkg::RST_NV[j];
        end else if (nv_wr[j]) begin
          nv_flags[j] <= nv_bad[j]; // RULE5 RULE6 RULE7 RULE8
        end
      end
    end
  endgenerate

  // ****************************************************************
  // time, calendar, alarm and mode registers
  // ****************************************************************
  // invalid words are still stored, the flag tells software about them
  // mode bit 0 picks the hour format that the entry check applies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_cfg <= rtm_pkg::RST_MODE;
    end else if (wr_mode) begin
      mode_cfg <= pwdata[rtm_pkg::MODE_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_value <= rtm_pkg::RST_WORD;
    end else if (wr_time) begin
      time_value <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_value <= rtm_pkg::RST_WORD;
    end else if (wr_cal) begin
      cal_value <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_alarm <= rtm_pkg::RST_WORD;
    end else if (wr_talr) begin
      time_alarm <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_alarm <= rtm_pkg::RST_WORD;
    end else if (wr_calr) begin
      cal_alarm <= pwdata;
    end
  end

  // ****************************************************************
  // write protection
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_protect_on <= rtm_pkg::RST_WP;
    end else if (wr_wp) begin
      write_protect_on <= pwdata[rtm_pkg::WP_ON_BIT]; // RULE9 RULE10
    end
  end

  // ****************************************************************
  // status flags and interrupt mask, one bit per source
  // ****************************************************************
  assign src_event[rtm_pkg::SRC_ACK]    = ev_update_ack;
  assign src_event[rtm_pkg::SRC_ALARM]  = ev_alarm_match; // RULE12
  assign src_event[rtm_pkg::SRC_SECOND] = ev_second;
  assign src_event[rtm_pkg::SRC_TIME]   = ev_time;
  assign src_event[rtm_pkg::SRC_CAL]    = ev_calendar;

  // per-bit strobes: a one acts on its bit, a zero leaves it alone
  logic [rtm_pkg::NUM_SRC-1:0] en_hit;
  logic [rtm_pkg::NUM_SRC-1:0] dis_hit;
  logic [rtm_pkg::NUM_SRC-1:0] clr_hit;

  genvar i;
  generate
    for (i = 0; i < rtm_pkg::NUM_SRC; i++) begin : g_src
      assign en_hit[i]  = wr_ien && pwdata[i];
      assign dis_hit[i] = wr_idis && pwdata[i];
      assign clr_hit[i] = wr_sclr && pwdata[i];

      // an event in the clearing cycle wins, so none is lost
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          status[i] <= rtm_pkg::RST_SRC[i];
        end else if (src_event[i]) begin
          status[i] <= 1'b1; // RULE12
        end else if (clr_hit[i]) begin
          status[i] <= 1'b0; // RULE13
        end
      end

      // enable and disable sit at different addresses, never both at once
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          irq_mask[i] <= rtm_pkg::RST_SRC[i];
        end else if (en_hit[i]) begin
          irq_mask[i] <= 1'b1; // RULE1
        end else if (dis_hit[i]) begin
          irq_mask[i] <= 1'b0; // RULE2 RULE3
        end
      end
    end
  endgenerate

  // ****************************************************************
  // interrupt output
  // ****************************************************************
  logic irq_pending;

  assign irq_pending = |(status & irq_mask); // RULE14

  // registered, so it trails the flag or mask change by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_pending; // RULE14
    end
  end

endmodule

// File: tb/rtm_regs_chk.sv
// assertion checker for the rtc mask, interrupt and protect registers
`timescale 1ns/10ps
module rtm_regs_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // events
  input wire logic        ev_update_ack,
  input wire logic        ev_alarm_match,
  input wire logic        ev_second,
  input wire logic        ev_time,
  input wire logic        ev_calendar,
  // configuration and interrupt
  input wire logic [7:0]  mode_cfg,
  input wire logic [31:0] time_alarm,
  input wire logic [31:0] cal_alarm,
  input wire logic        write_protect_on,
  input wire logic        irq
);
  // ****************************************************************
  // shadow of the mask, rebuilt from committed writes
  // ****************************************************************
  logic [4:0] msk;
  wire        wr  = psel && penable && pready && pwrite;
  wire        rd  = psel && penable && pready && !pwrite;
  wire        key = pwdata[31:8] == rtm_pkg::PROTECT_KEY;
  wire        wp  = wr && paddr == rtm_pkg::ADDR_WPMODE;
  wire        prt = wr && (paddr == rtm_pkg::ADDR_MODE ||
                    paddr == rtm_pkg::ADDR_TALR || paddr == rtm_pkg::ADDR_CALR);
  wire [4:0]  evs = {ev_calendar, ev_time, ev_second, ev_alarm_match,
                     ev_update_ack};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) msk <= rtm_pkg::RST_SRC;
    else if (wr && paddr == rtm_pkg::ADDR_IEN) msk <= msk | pwdata[4:0];
    else if (wr && paddr == rtm_pkg::ADDR_IDIS) msk <= msk & ~pwdata[4:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_irq;
    |($past(evs & {5{presetn}}) & msk) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_mrd;
    rd && paddr == rtm_pkg::ADDR_IMASK |-> prdata == {27'h000_0000, msk};
  endproperty
  a_mrd: assert property (p_mrd) else $error("mask read");
  property p_idis;
    wr && paddr == rtm_pkg::ADDR_IDIS && pwdata[4:0] == 5'h1f |=> ##1 !irq;
  endproperty
  a_idis: assert property (p_idis) else $error("irq after off");
  property p_sclr;
    wr && paddr == rtm_pkg::ADDR_SCLR && pwdata[4:0] == 5'h1f && evs == 5'h00
      |=> ##1 !irq;
  endproperty
  a_sclr: assert property (p_sclr) else $error("irq after clr");
  property p_prot;
    prt && write_protect_on
      |=> $stable(mode_cfg) && $stable(time_alarm) && $stable(cal_alarm);
  endproperty
  a_prot: assert property (p_prot) else $error("locked write");
  property p_wpon;
    wp && key && pwdata[0] |=> write_protect_on;
  endproperty
  a_wpon: assert property (p_wpon) else $error("lock not on");
  property p_wpoff;
    wp && key && !pwdata[0] |=> !write_protect_on;
  endproperty
  a_wpoff: assert property (p_wpoff) else $error("lock not off");
  property p_wkey;
    wp && !key |=> $stable(write_protect_on);
  endproperty
  a_wkey: assert property (p_wkey) else $error("bad key took");
endmodule
bind rtm_regs rtm_regs_chk chk_u (.*);

// File: tb/testbench.sv
// self-checking bench for the rtc mask, validity and protect registers
`timescale 1ns/10ps
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd_q;
  logic        pready, pslverr, irq, write_protect_on, err_q;
  logic [4:0]  ev = 5'h00;
  wire         ev_update_ack = ev[0];
  wire         ev_alarm_match = ev[1];
  wire         ev_second = ev[2];
  wire         ev_time = ev[3];
  wire         ev_calendar = ev[4];
  logic [7:0]  mode_cfg;
  logic [31:0] time_value, cal_value, time_alarm, cal_alarm;
  int          fail_count = 0, samples_checked = 0;
  rtm_regs dut_u (.*);
  initial begin
    forever #4 pclk = ~pclk;
  end
  // ****************************************************************
  // access and compare tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checked=%0d failed=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
    rd_q = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle cycle keeps two transfers from driving psel in one step
    @(posedge pclk);
  endtask
  task automatic wr(input logic [31:0] a, d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, exp);
    xfer(1'b0, a, '0);
    chk(rd_q, exp);
  endtask
  task automatic pulse(input int k);
    ev <= 5'h01 << k;
    @(posedge pclk);
    ev <= 5'h00;
    repeat (3) @(posedge pclk);
  endtask
  // ****************************************************************
  // tests
  // ****************************************************************
  logic [31:0] good [4] = '{32'h0012_3456, 32'h1565_2420, 32'h0012_3456,
                            32'h1505_0000};
  logic [31:0] bad [4]  = '{32'h0012_3460, 32'h1573_2420, 32'h0012_3460,
                            32'h1513_0000};
  logic [31:0] nva [4]  = '{rtm_pkg::ADDR_TIME, rtm_pkg::ADDR_CAL,
                            rtm_pkg::ADDR_TALR, rtm_pkg::ADDR_CALR};
  initial begin
    logic [31:0] m;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({31'h0000_0000, irq}, '0);
    rd(rtm_pkg::ADDR_IMASK, '0);
    rd(rtm_pkg::ADDR_VALID, '0);
    rd(rtm_pkg::ADDR_WPMODE, '0);
    rd(32'h400E_1300, '0);
    chk({31'h0000_0000, err_q}, 32'h0000_0001);
    $display("test reset done");
    m = '0;
    for (int k = 0; k < 5; k++) begin
      wr(rtm_pkg::ADDR_IEN, 32'h0000_0001 << k);
      m[k] = 1'b1;
      rd(rtm_pkg::ADDR_IMASK, m);
    end
    wr(rtm_pkg::ADDR_IEN, '0);
    wr(rtm_pkg::ADDR_IDIS, '0);
    wr(rtm_pkg::ADDR_IMASK, '0);
    rd(rtm_pkg::ADDR_IMASK, 32'h0000_001F);
    for (int k = 0; k < 5; k++) begin
      wr(rtm_pkg::ADDR_IDIS, 32'h0000_0001 << k);
      m[k] = 1'b0;
      rd(rtm_pkg::ADDR_IMASK, m);
    end
    $display("test mask done");
    for (int k = 0; k < 5; k++) begin
      wr(rtm_pkg::ADDR_IEN, 32'h0000_0001 << k);
      pulse(k);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      wr(rtm_pkg::ADDR_SCLR, '0);
      rd(rtm_pkg::ADDR_STATUS, 32'h0000_0001 << k);
      wr(rtm_pkg::ADDR_SCLR, 32'h0000_0001 << k);
      @(posedge pclk);
      chk({31'h0000_0000, irq}, '0);
      wr(rtm_pkg::ADDR_IDIS, 32'h0000_0001 << k);
      pulse(k);
      chk({31'h0000_0000, irq}, '0);
      wr(rtm_pkg::ADDR_SCLR, 32'h0000_001F);
    end
    wr(rtm_pkg::ADDR_IEN, 32'h0000_001F);
    pulse(2);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wr(rtm_pkg::ADDR_IDIS, 32'h0000_001F);
    @(posedge pclk);
    chk({31'h0000_0000, irq}, '0);
    rd(rtm_pkg::ADDR_IMASK, '0);
    rd(rtm_pkg::ADDR_STATUS, 32'h0000_0004);
    wr(rtm_pkg::ADDR_SCLR, 32'h0000_001F);
    rd(rtm_pkg::ADDR_STATUS, '0);
    $display("test irq done");
    for (int k = 0; k < 4; k++) begin
      wr(nva[k], bad[k]);
      rd(rtm_pkg::ADDR_VALID, 32'h0000_0001 << k);
      wr(nva[k], good[k]);
      rd(rtm_pkg::ADDR_VALID, '0);
    end
    chk(time_value, good[0]);
    chk(cal_value, good[1]);
    $display("test valid done");
    wr(rtm_pkg::ADDR_WPMODE, {24'h52_5442, 8'h01});
    rd(rtm_pkg::ADDR_WPMODE, '0);
    wr(rtm_pkg::ADDR_WPMODE, {rtm_pkg::PROTECT_KEY, 8'h01});
    rd(rtm_pkg::ADDR_WPMODE, 32'h0000_0001);
    chk({31'h0000_0000, write_protect_on}, 32'h0000_0001);
    wr(rtm_pkg::ADDR_TALR, 32'h0011_2233);
    wr(rtm_pkg::ADDR_CALR, 32'h1201_0000);
    wr(rtm_pkg::ADDR_MODE, 32'h0000_0001);
    chk(time_alarm, good[2]);
    chk(cal_alarm, good[3]);
    chk({24'h00_0000, mode_cfg}, '0);
    wr(rtm_pkg::ADDR_WPMODE, '0);
    rd(rtm_pkg::ADDR_WPMODE, 32'h0000_0001);
    wr(rtm_pkg::ADDR_WPMODE, {rtm_pkg::PROTECT_KEY, 8'h00});
    rd(rtm_pkg::ADDR_WPMODE, '0);
    wr(rtm_pkg::ADDR_TALR, 32'h0011_2233);
    chk(time_alarm, 32'h0011_2233);
    $display("test protect done");
    wr(rtm_pkg::ADDR_MODE, 32'h0000_0001);
    chk({24'h00_0000, mode_cfg}, 32'h0000_0001);
    wr(rtm_pkg::ADDR_TIME, 32'h0013_0000);
    rd(rtm_pkg::ADDR_VALID, 32'h0000_0001);
    wr(rtm_pkg::ADDR_TIME, 32'h0052_0000);
    rd(rtm_pkg::ADDR_VALID, '0);
    $display("test hour mode done");
    report_and_stop();
  end
endmodule
